//--- ucsd_regs.svh
`ifndef UCSD_REGS_SVH
`define UCSD_REGS_SVH
// ==========================================================
// Register indices; byte address is four times the index.
`define UCSD_IDX_CSA 10'h04e
`define UCSD_IDX_LINK 10'h04f
`define UCSD_IDX_STAT 10'h050
`define UCSD_CSA_RST 8'h07
`define UCSD_LINK_RST 8'h00
// ==========================================================
// Field positions in the chip select enable register.
`define UCSD_B_EXTBIOS 7
`define UCSD_B_LOWBIOS 6
`define UCSD_B_RANGE 5
`define UCSD_B_IDE 4
`define UCSD_B_FLOPHI 3
`define UCSD_B_FLOPLO 2
// Field positions in the linked control register.
`define UCSD_B_MSELSUB 4
`define UCSD_B_ISAFWD 3
// ==========================================================
// Encoded select codes; the no-select code is all ones.
`define UCSD_CODE_BIOS 3'h0
`define UCSD_CODE_IDE 3'h5
`define UCSD_CODE_NONE 3'h7
// ==========================================================
// Address windows.
`define UCSD_EXT_LO 32'hfff80000
`define UCSD_EXT_HI 32'hfffdffff
`define UCSD_LOW_PG0 16'h000e
`define UCSD_LOW_PG1 16'hfffe
`define UCSD_LOW_PG2 16'hffee
`define UCSD_IO_PG 16'h0000
`define UCSD_IDE_PRI_BLK 13'h003e
`define UCSD_IDE_SEC_BLK 13'h002e
`define UCSD_IDE_PRI_CTL 15'h01fb
`define UCSD_IDE_SEC_CTL 15'h01bb
`endif

//--- ucsd_pkg.sv
package ucsd_pkg;

    typedef enum logic [1:0] {
        UCSD_SRC_PCI = 2'b00,
        UCSD_SRC_ISA = 2'b01,
        UCSD_SRC_DMA = 2'b10
    } ucsd_src_e;

    typedef enum logic [1:0] {
        UCSD_APB_IDLE = 2'b00,
        UCSD_APB_RESP = 2'b01
    } ucsd_apb_e;

    typedef struct packed {
        logic valid;
        ucsd_src_e src;
        logic isIo;
        logic [31:0] addr;
    } ucsd_req_s;

    typedef struct packed {
        logic valid;
        logic [2:0] code;
        logic xcvrEnN;
        logic positive;
        logic forward;
    } ucsd_res_s;

endpackage

//--- ucsd_decode.sv
// Register access over APB was decided locally.
`include "ucsd_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ucsd_decode #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    input wire logic host_bus_reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ucsd_pkg::ucsd_req_s accReq,
    output ucsd_pkg::ucsd_res_s accRes,
    output logic [7:0] utility_chip_select_enable_a
);
    import ucsd_pkg::*;

    // ==========================================================
    // Host bus reset synchroniser.
    // The pin is asynchronous to mclk, so it passes two flops
    // before it may reload both registers.
    logic hostRstMeta_q;
    logic hostRstSync_q;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            hostRstMeta_q <= 1'b1;
            hostRstSync_q <= 1'b1;
        end
        else if (ce)
        begin
            hostRstMeta_q <= host_bus_reset_n;
            hostRstSync_q <= hostRstMeta_q;
        end
    end

    wire regReset = sys_rst | ~hostRstSync_q;

    // ==========================================================
    // APB slave.
    ucsd_apb_e apbState_q;
    ucsd_apb_e apbState_d;
    logic [7:0] csa_q;
    logic [7:0] csa_d;
    logic [7:0] link_q;
    logic [7:0] link_d;
    logic [7:0] stat_q;
    logic [31:0] prdata_q;
    logic pslverr_q;

    wire [ADDR_W-3:0] regIdx = paddr[ADDR_W-1:2];
    wire idxCsa = regIdx == (ADDR_W-2)'(`UCSD_IDX_CSA);
    wire idxLink = regIdx == (ADDR_W-2)'(`UCSD_IDX_LINK);
    wire idxStat = regIdx == (ADDR_W-2)'(`UCSD_IDX_STAT);
    wire idxHit = idxCsa | idxLink | idxStat;
    wire apbAccess = psel & penable;
    wire apbTake = apbAccess & (apbState_q == UCSD_APB_IDLE);
    wire apbCommit = apbAccess & (apbState_q == UCSD_APB_RESP);
    wire wrCsa = apbCommit & pwrite & idxCsa;
    wire wrLink = apbCommit & pwrite & idxLink;
    wire [7:0] rdByte = idxCsa ? csa_q :
                        idxLink ? link_q :
                        idxStat ? stat_q : 8'h00;

    // One wait state: the answer is registered so pready and
    // prdata come straight from flops.
    always_comb
    begin
        apbState_d = apbState_q;
        unique case (apbState_q)
            UCSD_APB_IDLE:
            begin
                if (apbTake)
                    apbState_d = UCSD_APB_RESP;
            end
            UCSD_APB_RESP:
            begin
                apbState_d = UCSD_APB_IDLE;
            end
            default:
            begin
                apbState_d = UCSD_APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            apbState_q <= UCSD_APB_IDLE;
            prdata_q <= 32'h00000000;
            pslverr_q <= 1'b0;
        end
        else if (ce)
        begin
            apbState_q <= apbState_d;
            if (apbTake)
            begin
                prdata_q <= {24'h000000, pwrite ? 8'h00 : rdByte};
                pslverr_q <= ~idxHit;
            end
        end
    end

    // An unmapped index answers with an error and reads zero; a write
    // to it or to the read-only status index changes nothing.
    assign pready = apbState_q == UCSD_APB_RESP;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    // ==========================================================
    // Configuration registers.
    // Bits 3:0 of the enable register are held for software only;
    // their peripherals are not decoded here.
    assign csa_d = wrCsa ? pwdata[7:0] : csa_q;
    assign link_d = wrLink ? pwdata[7:0] : link_q;

    // A host bus reset reloads both registers but leaves the bus slave
    // running, so software can still poll them while the pin is held.
    always_ff @(posedge mclk)
    begin
        if (regReset)
        begin
            csa_q <= `UCSD_CSA_RST;
            link_q <= `UCSD_LINK_RST;
        end
        else if (ce)
        begin
            csa_q <= csa_d;
            link_q <= link_d;
        end
    end

    assign utility_chip_select_enable_a = csa_q;

    // ==========================================================
    // Address decode from the live register contents.
    wire extEn = csa_q[`UCSD_B_EXTBIOS];
    wire lowEn = csa_q[`UCSD_B_LOWBIOS];
    wire rangeSec = csa_q[`UCSD_B_RANGE];
    wire ideEn = csa_q[`UCSD_B_IDE];
    wire mselSub = link_q[`UCSD_B_MSELSUB];
    wire isaFwd = link_q[`UCSD_B_ISAFWD];

    wire [31:0] a = accReq.addr;
    wire isMem = accReq.valid & ~accReq.isIo;
    wire isIo = accReq.valid & accReq.isIo;
    wire srcPci = accReq.src == UCSD_SRC_PCI;
    wire srcIsa = accReq.src == UCSD_SRC_ISA;

    wire extHit = isMem & (a >= `UCSD_EXT_LO) & (a <= `UCSD_EXT_HI);
    wire lowHit = isMem & ((a[31:16] == `UCSD_LOW_PG0) | (a[31:16] == `UCSD_LOW_PG1)
                  | (a[31:16] == `UCSD_LOW_PG2));
    wire ioPage = isIo & (a[31:16] == `UCSD_IO_PG);
    wire idePriHit = ioPage & ((a[15:3] == `UCSD_IDE_PRI_BLK) | (a[15:1] == `UCSD_IDE_PRI_CTL));
    wire ideSecHit = ioPage & ((a[15:3] == `UCSD_IDE_SEC_BLK) | (a[15:1] == `UCSD_IDE_SEC_CTL));
    wire ideHit = rangeSec ? ideSecHit : idePriHit;

    wire extSel = extHit & srcPci & extEn;
    wire lowSel = lowHit & (srcPci | srcIsa) & lowEn;
    wire ideSel = ideHit & ideEn;
    wire biosSel = extSel | lowSel;

    // BIOS and IDE hits cannot coincide: one needs a memory cycle and
    // the other an I/O cycle, so the priority below is only a formality.
    wire [2:0] codeD = biosSel ? `UCSD_CODE_BIOS :
                       ideSel ? `UCSD_CODE_IDE : `UCSD_CODE_NONE;
    wire xcvrD = biosSel | ideSel;
    wire posD = srcPci & (extSel | (lowSel & ~mselSub));
    // Only lower BIOS hits are judged here; other ISA or DMA
    // addresses are forwarded by logic outside this block.
    wire fwdD = ~srcPci & lowHit & ~lowEn & isaFwd;

    // The status copy gives software a view of the last decoded
    // request without a tap on the access path.
    ucsd_res_s res_q;

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            res_q <= '{valid: 1'b0, code: `UCSD_CODE_NONE, xcvrEnN: 1'b1,
                       positive: 1'b0, forward: 1'b0};
            stat_q <= 8'h00;
        end
        else if (ce)
        begin
            res_q <= '{valid: accReq.valid, code: codeD, xcvrEnN: ~xcvrD,
                       positive: posD, forward: fwdD};
            if (accReq.valid)
                stat_q <= {2'b00, fwdD, posD, ~xcvrD, codeD};
        end
    end

    assign accRes = res_q;

    // ==========================================================
    // Checks.
    // Every decode check compares the registered result one edge
    // after the request, since that is where the block answers.
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    sequence s_ext_access;
        ce & extHit & srcPci;
    endsequence

    sequence s_low_access;
        ce & lowHit & lowEn;
    endsequence

    sequence s_apb_write_csa;
        ce & wrCsa;
    endsequence

    sequence s_host_rst_held;
        ce && !host_bus_reset_n ##1 ce && !host_bus_reset_n;
    endsequence

    a_ext_bios_on: assert property (
        s_ext_access ##0 extEn |=> accRes.code == `UCSD_CODE_BIOS && !accRes.xcvrEnN && accRes.positive)
        else $error("extended BIOS access not selected");

    a_ext_bios_off: assert property (
        s_ext_access ##0 !extEn |=> accRes.code == `UCSD_CODE_NONE && accRes.xcvrEnN)
        else $error("extended BIOS select while disabled");

    a_low_bios_code: assert property (
        s_low_access ##0 (srcPci || srcIsa) |=> accRes.code == `UCSD_CODE_BIOS)
        else $error("lower BIOS code missing");

    a_low_bios_pos: assert property (
        s_low_access ##0 srcPci |=> accRes.positive == !$past(mselSub))
        else $error("lower BIOS decode mode wrong");

    a_low_bios_nofwd: assert property (
        s_low_access ##0 !srcPci |=> !accRes.forward)
        else $error("lower BIOS forwarded while enabled");

    a_low_bios_off: assert property (
        ce && lowHit && !lowEn && !srcPci |=>
            accRes.code == `UCSD_CODE_NONE && accRes.forward == $past(isaFwd))
        else $error("disabled lower BIOS handled wrong");

    a_ide_select: assert property (
        ce && ideEn && (rangeSec ? ideSecHit : idePriHit) |=>
            accRes.code == `UCSD_CODE_IDE && !accRes.xcvrEnN)
        else $error("IDE address not selected");

    a_ide_disabled: assert property (
        ce && !ideEn && (idePriHit || ideSecHit) |=> accRes.code == `UCSD_CODE_NONE && accRes.xcvrEnN)
        else $error("IDE select while disabled");

    a_range_single: assert property (
        ce && ideEn && (rangeSec ? idePriHit : ideSecHit) |=> accRes.code == `UCSD_CODE_NONE)
        else $error("inactive IDE range decoded");

    a_reset_value: assert property (
        ce && !hostRstSync_q |=> csa_q[`UCSD_B_FLOPLO] && !csa_q[`UCSD_B_FLOPHI] && !csa_q[`UCSD_B_RANGE])
        else $error("host bus reset value wrong");

    a_write_effect: assert property (
        s_apb_write_csa ##0 hostRstSync_q |=> csa_q == $past(pwdata[7:0]))
        else $error("register write not applied");

    a_no_enable_nil: assert property (
        ce && !xcvrD |=> accRes.xcvrEnN && accRes.code == `UCSD_CODE_NONE)
        else $error("select without enabled peripheral");

    a_apb_answer: assert property (
        ce && apbTake |=> pready ##1 !pready)
        else $error("APB answer timing wrong");

    a_apb_error_resp: assert property (
        ce && apbTake |=> pready && pslverr == !$past(idxHit))
        else $error("APB error response wrong");

    a_read_upper_zero: assert property (
        pready |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");

    a_unmapped_ignored: assert property (
        ce && apbCommit && pwrite && !idxCsa && !idxLink && hostRstSync_q |=>
            $stable(csa_q) && $stable(link_q))
        else $error("write outside the writable registers landed");

    a_link_write: assert property (
        ce && wrLink && hostRstSync_q |=> link_q == $past(pwdata[7:0]))
        else $error("linked control write not applied");

    // The pin is sampled raw here: two synchroniser stages and the load make three edges.
    a_host_rst_load: assert property (
        s_host_rst_held |=> ##1 (csa_q == `UCSD_CSA_RST && link_q == `UCSD_LINK_RST))
        else $error("host bus reset did not reload registers");

    a_ext_not_isa: assert property (
        ce && extHit && !srcPci |=> accRes.code == `UCSD_CODE_NONE && accRes.xcvrEnN)
        else $error("extended BIOS selected for a non-PCI master");

    a_low_bios_xcvr: assert property (
        s_low_access ##0 (srcPci || srcIsa) |=> !accRes.xcvrEnN)
        else $error("lower BIOS transceiver enable missing");

    a_pci_no_forward: assert property (
        ce && accReq.valid && srcPci |=> !accRes.forward)
        else $error("PCI access reported as forwarded");

    a_stat_track: assert property (
        ce && accReq.valid |=>
            stat_q == {2'b00, accRes.forward, accRes.positive, accRes.xcvrEnN, accRes.code})
        else $error("status copy out of step");

    // Excludes the edge at which a held host bus reset reloads the registers.
    a_ce_freeze: assert property (
        !ce && hostRstSync_q |=> $stable(csa_q) && $stable(link_q) && $stable(apbState_q) && $stable(accRes))
        else $error("state moved while clock enable low");

endmodule // ucsd_decode

`default_nettype wire

//--- ucsd_master_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Access-side master model.
// For each cycle of gap before a request it drops valid and scrambles the address.
// A stale request then cannot pass for a fresh one.
module ucsd_master_model (
    input wire logic mclk,
    output ucsd_pkg::ucsd_req_s accReq
);
    import ucsd_pkg::*;

    initial accReq = '0;

    task automatic issue(input int gap, input ucsd_src_e src, input logic io, input logic [31:0] addr);
        repeat (gap)
        begin
            @(posedge mclk);
            accReq <= '{valid: 1'b0, src: UCSD_SRC_DMA, isIo: ~io, addr: ~accReq.addr};
        end
        @(posedge mclk);
        accReq <= '{valid: 1'b1, src: src, isIo: io, addr: addr};
    endtask
endmodule // ucsd_master_model
`default_nettype wire

//--- utility_bus_chip_select_decode_a_tb.sv
`include "ucsd_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module utility_bus_chip_select_decode_a_tb;
    import ucsd_pkg::*;
    // ==========================================================
    // Stimulus and design.
    localparam logic [11:0] A_CSA = {`UCSD_IDX_CSA, 2'b00};
    localparam logic [11:0] A_LINK = {`UCSD_IDX_LINK, 2'b00};
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic hostRstN = 1'b1;
    logic clkEn = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [7:0] csaReg;
    ucsd_req_s accReq;
    ucsd_res_s accRes;
    int errors = 0, cmp_count = 0;
    logic [31:0] tAddr [15] = '{32'hfff80000, 32'hfffdffff, 32'hfff7ffff, 32'hfff80000, 32'h000e0000,
        32'h000effff, 32'hfffe1234, 32'hffee8000, 32'h000d0000, 32'h000001f0, 32'h000001f7,
        32'h000003f7, 32'h00000170, 32'h00000377, 32'h000001f8};
    logic [1:0] tSrc [15] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h0,
        2'h1, 2'h0};
    logic [14:0] tIo = 15'h7e00;
    logic [7:0] tCfg [6] = '{8'h07, 8'h87, 8'h47, 8'h53, 8'h77, 8'hff};

    always #2.5 mclk = ~mclk;

    ucsd_decode #(.ADDR_W(12)) i_dut (.mclk(mclk), .sys_rst(sysRst), .ce(clkEn), .host_bus_reset_n(hostRstN),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .accReq(accReq), .accRes(accRes),
        .utility_chip_select_enable_a(csaReg));
    ucsd_master_model i_master (.mclk(mclk), .accReq(accReq));

    // ==========================================================
    // Checking and bus tasks.
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            errors++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, rd, err);
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [7:0] d);
        apb(1'b0, a, 32'h0, rd, err);
        chk({rd[30:0], err}, {23'h0, d, 1'b0});
    endtask

    // Expected decode result, packed like the result struct.
    function automatic logic [6:0] expd(logic [7:0] e, logic [7:0] l, logic [1:0] s, logic io, logic [31:0] a);
        logic [2:0] c;
        logic x, p, f, low, ide;
        c = 3'h7;
        x = 1'b1;
        p = 1'b0;
        f = 1'b0;
        low = !io && (a[31:16] == 16'h000e || a[31:16] == 16'hfffe || a[31:16] == 16'hffee);
        ide = io && a[31:16] == 16'h0000 && e[4] && (e[5] ? (a[15:3] == 13'h002e || a[15:1] == 15'h01bb)
            : (a[15:3] == 13'h003e || a[15:1] == 15'h01fb));
        if (!io && s == 2'h0 && a >= 32'hfff80000 && a <= 32'hfffdffff && e[7])
            {c, x, p} = {3'h0, 1'b0, 1'b1};
        if (low && e[6] && s != 2'h2)
            {c, x, p} = {3'h0, 1'b0, s == 2'h0 && !l[4]};
        if (low && s != 2'h0)
            f = !e[6] && l[3];
        if (ide)
            {c, x} = {3'h5, 1'b0};
        return {1'b1, c, x, p, f};
    endfunction

    // ==========================================================
    // Test sequence.
    initial
    begin
        repeat (5000) @(posedge mclk);
        errors++;
        summarize();
    end

    initial
    begin
        repeat (4) @(posedge mclk);
        sysRst <= 1'b0;
        rdchk(A_CSA, 8'h07);
        rdchk(A_LINK, 8'h00);
        apb(1'b0, 12'h144, 32'h0, rd, err);
        chk({rd[30:0], err}, 32'h1);
        apb(1'b1, 12'h144, 32'h000000ff, rd, err);
        chk({31'h0, err}, 32'h1);
        rdchk(A_CSA, 8'h07);
        for (int i = 0; i < 6; i++)
        begin
            wr(A_LINK, i[0] ? 8'h18 : 8'h00);
            wr(A_CSA, tCfg[i]);
            @(posedge mclk);
            chk({24'h0, csaReg}, {24'h0, tCfg[i]});
            for (int k = 0; k < 15; k++)
            begin
                i_master.issue(k % 2, ucsd_src_e'(tSrc[k]), tIo[k], tAddr[k]);
                @(posedge mclk);
                #1;
                chk(32'(accRes), 32'(expd(tCfg[i], i[0] ? 8'h18 : 8'h00, tSrc[k], tIo[k], tAddr[k])));
            end
        end
        rdchk(12'h140, 8'h0f);
        wr(A_CSA, 8'hff);
        hostRstN <= 1'b0;
        repeat (4) @(posedge mclk);
        rdchk(A_CSA, 8'h07);
        wr(A_CSA, 8'hff);
        rdchk(A_CSA, 8'h07);
        hostRstN <= 1'b1;
        repeat (4) @(posedge mclk);
        wr(A_CSA, 8'h20);
        rdchk(A_CSA, 8'h20);
        clkEn <= 1'b0;
        fork
            begin
                repeat (6) @(posedge mclk);
                clkEn <= 1'b1;
            end
        join_none
        wr(A_CSA, 8'h87);
        @(posedge mclk);
        chk({24'h0, csaReg}, 32'h00000087);
        summarize();
    end
endmodule // utility_bus_chip_select_decode_a_tb
`default_nettype wire
